// >>> design/relpi_core.sv
// Relay PI pulse controller core with an APB register slave.
// Assumes the measured value is written by software; one clock, sync reset.
// Function
// - Each second add error times integral gain over sixty to integral.
// - Integral gain counts as gain per minute of full output.
// - Constant nonzero error keeps growing the integral each second until a limit.
// - Integral gain signed, one decimal, default zero; zero stops it.
// - High limit caps positive integral, 0.0 to 100.0, default 100.0.
// - Negative integral clamped to low limit, 0.0 to 100.0 percent.
// - High and low limits act independently around the bias.
// - Bias sets duty at setpoint, 0.0 to 100.0, default 50.0.
// - Cycle period 0.0 to 5000.0 s, default 0.0, spans one cycle.
// - Frequency mode pulse lasts the on time; zero disables the relay.
// - Proportional term is gain times error over span; sign reverses.
// - Output steers the measured value toward the target value.
`timescale 1ns/1ps
module relpi_core
  import relpi_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Relay drive
  output logic             relay_out
);

  logic               ctrl_en;
  logic               ctrl_freq;
  logic signed [15:0] control_target_value;
  logic signed [15:0] meas;
  logic signed [15:0] pgain;
  logic signed [15:0] igain;
  logic        [15:0] span;
  logic        [15:0] hi_lim;
  logic        [15:0] lo_lim;
  logic        [15:0] steady_output_offset;
  logic        [15:0] cycle_period_seconds;
  logic        [15:0] on_time;
  logic        [19:0] div_cnt;
  logic               tick;
  logic        [3:0]  tenth_cnt;
  logic               sec_tick;
  logic signed [33:0] span_s;
  logic signed [33:0] err_c;
  logic signed [33:0] p_term;
  logic signed [33:0] i_inc;
  logic signed [33:0] i_term;
  logic signed [33:0] hi_cap;
  logic signed [33:0] lo_cap;
  logic signed [33:0] next_acc;
  logic signed [33:0] out_sum;
  logic signed [23:0] acc;
  logic        [9:0]  out_pct;
  logic        [31:0] cyc_cnt;
  logic        [31:0] cyc_len;
  logic        [31:0] on_len;
  logic        [31:0] next_cyc;
  logic        [31:0] next_on;
  logic               restart;
  logic               force_off;
  logic        [31:0] rd_data;
  logic               hit;
  logic               wr_en;

  function automatic logic signed [33:0] sat(input logic signed [33:0] x,
                                             input logic signed [33:0] lo,
                                             input logic signed [33:0] hi);
    if (x < lo) return lo;
    if (x > hi) return hi;
    return x;
  endfunction

  function automatic logic [15:0] cap(input logic [15:0] v,
                                      input logic [15:0] m);
    return (v > m) ? m : v;
  endfunction

  function automatic logic signed [33:0] su(input logic [15:0] v);
    return $signed({18'h0, v});
  endfunction

  function automatic logic signed [33:0] ss(input logic signed [15:0] v);
    return 34'(v);
  endfunction

  // Control time base: tenth-second tick, then whole seconds
  always_ff @(posedge clk) begin
    if (srst) begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end else if (div_cnt == 20'(TICK_CYC - 1)) begin
      div_cnt <= '0;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 20'h1;
      tick    <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tenth_cnt <= '0;
      sec_tick  <= 1'b0;
    end else if (tick && tenth_cnt == TICKS_PER_SEC - 4'h1) begin
      tenth_cnt <= '0;
      sec_tick  <= 1'b1;
    end else begin
      tenth_cnt <= tick ? tenth_cnt + 4'h1 : tenth_cnt;
      sec_tick  <= 1'b0;
    end
  end

  // Error saturates at one span so gains read as percent of full output
  always_comb begin
    span_s = su((span == 16'h0) ? SPAN_MIN : span);
    err_c  = sat(ss(control_target_value) - ss(meas),
                 -span_s, span_s);
    p_term = (ss(pgain) * err_c) / span_s;
    // Integral kept in sixtieths so small per-second steps are not lost
    i_inc  = (ss(igain) * err_c) / span_s;
    i_term = 34'(acc) / SEC_PER_MIN;
    hi_cap = su(hi_lim) * SEC_PER_MIN;
    lo_cap = su(lo_lim) * SEC_PER_MIN;
    next_acc = sat(34'(acc) + (sec_tick ? i_inc : 34'sh0),
                   -lo_cap, hi_cap);
    out_sum = su(steady_output_offset) + p_term + i_term;
  end

  // Integral clears while disabled to avoid windup before start
  always_ff @(posedge clk) begin
    if (srst) begin
      acc <= '0;
    end else if (!ctrl_en) begin
      acc <= '0;
    end else begin
      acc <= next_acc[23:0];
    end
  end

  chk_integ_hold: assert property (@(posedge clk) disable iff (srst)
    ctrl_en && !sec_tick && 34'(acc) <= hi_cap && 34'(acc) >= -lo_cap
    |=> acc == $past(acc))
    else $error("integral changed outside a second tick");

  chk_integ_zero: assert property (@(posedge clk) disable iff (srst)
    ctrl_en && igain == 16'sh0 && 34'(acc) <= hi_cap &&
    34'(acc) >= -lo_cap |=> acc == $past(acc))
    else $error("integral moved with zero integral gain");

  chk_integ_rise: assert property (@(posedge clk) disable iff (srst)
    ctrl_en && sec_tick && i_inc > 34'sh0 && 34'(acc) >= -lo_cap &&
    34'(acc) + i_inc <= hi_cap |=> acc > $past(acc))
    else $error("integral did not grow with constant error");

  chk_integ_high: assert property (@(posedge clk) disable iff (srst)
    ctrl_en ##1 ctrl_en |-> 34'(acc) <= $past(hi_cap))
    else $error("integral above high limit");

  chk_integ_low: assert property (@(posedge clk) disable iff (srst)
    ctrl_en ##1 ctrl_en |-> 34'(acc) >= -$past(lo_cap))
    else $error("integral below low limit");

  always_ff @(posedge clk) begin
    if (srst) begin
      out_pct <= '0;
    end else begin
      out_pct <= 10'(sat(out_sum, 34'sh0, su(PCT_FULL)));
    end
  end

  chk_out_range: assert property (@(posedge clk) disable iff (srst)
    out_pct <= 10'(PCT_FULL))
    else $error("output percent out of range");

  chk_out_floor: assert property (@(posedge clk) disable iff (srst)
    out_sum <= 34'sh0 |=> out_pct == 10'h0)
    else $error("output percent not zero for a negative sum");

  // New lengths are taken only at a cycle boundary, so a cycle never tears
  always_comb begin
    restart  = (cyc_cnt + 32'h1 >= cyc_len);
    next_cyc = cyc_len;
    next_on  = on_len;
    if (restart) begin
      if (ctrl_freq) begin
        if (out_pct == 10'h0 || on_time == 16'h0) begin
          next_cyc = '0;
          next_on  = '0;
        end else begin
          next_cyc = (32'(on_time) * FREQ_DUTY_DEN * 32'(PCT_FULL))
                     / 32'(out_pct);
          next_on  = 32'(on_time);
        end
      end else begin
        next_cyc = 32'(cycle_period_seconds);
        next_on  = (32'(cycle_period_seconds) * 32'(out_pct))
                   / 32'(PCT_FULL);
      end
    end
    force_off = ctrl_freq ? (on_time == 16'h0)
                          : (cycle_period_seconds == 16'h0);
  end

  always_ff @(posedge clk) begin
    if (srst || !ctrl_en) begin
      cyc_cnt <= '0;
      cyc_len <= '0;
      on_len  <= '0;
    end else if (tick) begin
      cyc_cnt <= restart ? 32'h0 : cyc_cnt + 32'h1;
      cyc_len <= next_cyc;
      on_len  <= next_on;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      relay_out <= 1'b0;
    end else begin
      relay_out <= ctrl_en && !force_off && (cyc_cnt < on_len);
    end
  end

  chk_freq_off: assert property (@(posedge clk) disable iff (srst)
    ctrl_freq && on_time == 16'h0 |=> !relay_out)
    else $error("relay on with zero on time");

  chk_period_off: assert property (@(posedge clk) disable iff (srst)
    !ctrl_freq && cycle_period_seconds == 16'h0 |=> !relay_out)
    else $error("relay on with zero cycle period");

  chk_cycle_start: assert property(@(posedge clk) disable iff (srst)
    ctrl_en && !force_off && cyc_cnt == 32'h0 && on_len != 32'h0
    |=> relay_out)
    else $error("relay off at start of a cycle with nonzero duty");

  // APB read decode
  always_comb begin
    hit     = 1'b1;
    rd_data = '0;
    case (paddr)
      OFS_CTRL:   rd_data = 32'({ctrl_freq, ctrl_en});
      OFS_TARGET: rd_data = 32'(control_target_value);
      OFS_MEAS:   rd_data = 32'(meas);
      OFS_SPAN:   rd_data = 32'(span);
      OFS_PGAIN:  rd_data = 32'(pgain);
      OFS_IGAIN:  rd_data = 32'(igain);
      OFS_HILIM:  rd_data = 32'(hi_lim);
      OFS_LOLIM:  rd_data = 32'(lo_lim);
      OFS_OFFSET: rd_data = 32'(steady_output_offset);
      OFS_PERIOD: rd_data = 32'(cycle_period_seconds);
      OFS_ONTIME: rd_data = 32'(on_time);
      OFS_OUTPUT: rd_data = 32'(out_pct);
      OFS_INTEG:  rd_data = i_term[31:0];
      OFS_STATUS: begin
        rd_data[STAT_RLY_BIT] = relay_out;
        rd_data[STAT_RUN_BIT] = (cyc_len != 32'h0);
      end
      default:    hit     = 1'b0;
    endcase
  end

  assign wr_en = psel && penable && pready && pwrite && hit;

  // One wait state; answer registered so outputs come from flip-flops
  always_ff @(posedge clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit;
      prdata  <= (psel && penable && !pready && !pwrite) ? rd_data : '0;
    end
  end

  // Out-of-range settings are capped on write rather than refused
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_en              <= 1'b0;
      ctrl_freq            <= 1'b0;
      control_target_value <= RST_TARGET;
      meas                 <= '0;
      span                 <= RST_SPAN;
      pgain                <= RST_PGAIN;
      igain                <= RST_IGAIN;
      hi_lim               <= RST_HILIM;
      lo_lim               <= RST_LOLIM;
      steady_output_offset <= RST_OFFSET;
      cycle_period_seconds <= RST_PERIOD;
      on_time              <= RST_ONTIME;
    end else if (wr_en) begin
      case (paddr)
        OFS_CTRL: begin
          ctrl_en   <= pwdata[CTRL_EN_BIT];
          ctrl_freq <= pwdata[CTRL_FREQ_BIT];
        end
        OFS_TARGET: control_target_value <= pwdata[15:0];
        OFS_MEAS:   meas                 <= pwdata[15:0];
        OFS_SPAN:   span                 <= pwdata[15:0];
        OFS_PGAIN:  pgain                <= pwdata[15:0];
        OFS_IGAIN:  igain                <= pwdata[15:0];
        OFS_HILIM:  hi_lim               <= cap(pwdata[15:0], PCT_FULL);
        OFS_LOLIM:  lo_lim               <= cap(pwdata[15:0], PCT_FULL);
        OFS_OFFSET: steady_output_offset <= cap(pwdata[15:0], PCT_FULL);
        OFS_PERIOD: cycle_period_seconds <= cap(pwdata[15:0], TIME_MAX);
        OFS_ONTIME: on_time              <= cap(pwdata[15:0], TIME_MAX);
        default: begin
        end
      endcase
    end
  end

endmodule

// >>> inc/relpi_pkg.sv
// Constants for the relay PI pulse controller: register map, reset values,
// scaling and time base. Assumes a 10 MHz system clock.
package relpi_pkg;
  // Time base
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned TICK_MS       = 100;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam logic [3:0]  TICKS_PER_SEC = 4'hA;
  localparam logic signed [33:0] SEC_PER_MIN = 34'sh3C;

  // Scaling: percent in tenths, times in tenths of a second
  localparam logic [15:0] PCT_FULL      = 16'h03E8;
  localparam logic [15:0] TIME_MAX      = 16'hC350;
  localparam logic [15:0] SPAN_MIN      = 16'h0001;
  localparam logic [31:0] FREQ_DUTY_DEN = 32'h2;

  // Register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TARGET = 8'h04;
  localparam logic [7:0] OFS_MEAS   = 8'h08;
  localparam logic [7:0] OFS_SPAN   = 8'h0C;
  localparam logic [7:0] OFS_PGAIN  = 8'h10;
  localparam logic [7:0] OFS_IGAIN  = 8'h14;
  localparam logic [7:0] OFS_HILIM  = 8'h18;
  localparam logic [7:0] OFS_LOLIM  = 8'h1C;
  localparam logic [7:0] OFS_OFFSET = 8'h20;
  localparam logic [7:0] OFS_PERIOD = 8'h24;
  localparam logic [7:0] OFS_ONTIME = 8'h28;
  localparam logic [7:0] OFS_OUTPUT = 8'h2C;
  localparam logic [7:0] OFS_INTEG  = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;

  // Field positions
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_FREQ_BIT = 1;
  localparam int unsigned STAT_RLY_BIT  = 0;
  localparam int unsigned STAT_RUN_BIT  = 1;

  // Reset values
  localparam logic [15:0] RST_TARGET = 16'h03E8;
  localparam logic [15:0] RST_SPAN   = 16'h000A;
  localparam logic [15:0] RST_PGAIN  = 16'h000A;
  localparam logic [15:0] RST_IGAIN  = 16'h0000;
  localparam logic [15:0] RST_HILIM  = 16'h03E8;
  localparam logic [15:0] RST_LOLIM  = 16'h03E8;
  localparam logic [15:0] RST_OFFSET = 16'h01F4;
  localparam logic [15:0] RST_PERIOD = 16'h0000;
  localparam logic [15:0] RST_ONTIME = 16'h0000;
endpackage

// >>> test/relpi_core_tb.sv
// Testbench for the relay PI core: APB register access and relay timing.
// Assumes one APB wait state and a shortened tick of 4 clocks.
`timescale 1ns/1ps
module relpi_core_tb;
  import relpi_pkg::*;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr;
  logic        relay_out, clr, err_seen;
  logic [7:0]  paddr, rises, falls;
  logic [31:0] pwdata, prdata, rd_a, rd_b;
  logic [15:0] on_clks, per_clks;
  int          error_cnt, num_checks;

  relpi_core #(.TICK_CYC(4)) DUT (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .relay_out(relay_out));
  relpi_relay_load load (.clk(clk), .clr(clr), .relay_out(relay_out),
    .on_clks(on_clks), .per_clks(per_clks), .rises(rises), .falls(falls));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      tally_and_finish();
    end
    q = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd_b);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rd_a);
    check(rd_a, e);
  endtask

  // Restart the load's measurements from the present line level
  task automatic flush(input int settle);
    repeat (settle) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask

  task automatic wait_rises();
    int n;
    n = 0;
    while (rises < 8'h03 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  task automatic idle_check(input logic lvl);
    repeat (80) @(posedge clk);
    check({24'h0, lvl ? falls : rises}, 32'h0);
    check({31'h0, relay_out}, {31'h0, lvl});
    rchk(OFS_STATUS, {30'h0, 1'b1, lvl});
  endtask

  task automatic t_reset();
    rchk(OFS_IGAIN, 32'h0000_0000);
    rchk(OFS_HILIM, 32'h0000_03E8);
    rchk(OFS_OFFSET, 32'h0000_01F4);
    rchk(OFS_PERIOD, 32'h0000_0000);
    rchk(OFS_ONTIME, 32'h0000_0000);
    rchk(8'h38, 32'h0000_0000);
    check({31'h0, err_seen}, 32'h1);
    wr(OFS_HILIM, 32'h0000_07D0);
    rchk(OFS_HILIM, 32'h0000_03E8);
    wr(OFS_PERIOD, 32'h0000_EA60);
    rchk(OFS_PERIOD, 32'h0000_C350);
    $display("test reset done");
  endtask

  task automatic t_pwm();
    wr(OFS_PGAIN, 32'h0);
    wr(OFS_OFFSET, 32'h0000_012C);
    wr(OFS_PERIOD, 32'h0000_000A);
    wr(OFS_CTRL, 32'h1);
    flush(50);
    wait_rises();
    check({16'h0, on_clks}, 32'h0000_000C);
    check({16'h0, per_clks}, 32'h0000_0028);
    wr(OFS_OFFSET, 32'h0);
    flush(50);
    idle_check(1'b0);
    wr(OFS_OFFSET, 32'h0000_03E8);
    flush(50);
    idle_check(1'b1);
    $display("test pwm done");
  endtask

  task automatic t_prop();
    wr(OFS_MEAS, 32'h0000_03E3);
    wr(OFS_PGAIN, 32'h0000_03E8);
    wr(OFS_OFFSET, 32'h0000_00C8);
    rchk(OFS_OUTPUT, 32'h0000_02BC);
    wr(OFS_PGAIN, 32'hFFFF_FC18);
    wr(OFS_OFFSET, 32'h0000_02BC);
    rchk(OFS_OUTPUT, 32'h0000_00C8);
    wr(OFS_MEAS, 32'h0);
    rchk(OFS_OUTPUT, 32'h0000_0000);
    wr(OFS_PGAIN, 32'h0000_03E8);
    rchk(OFS_OUTPUT, 32'h0000_03E8);
    $display("test proportional done");
  endtask

  task automatic t_integ();
    wr(OFS_CTRL, 32'h0);
    wr(OFS_PGAIN, 32'h1);
    wr(OFS_OFFSET, 32'h0000_01F4);
    wr(OFS_IGAIN, 32'h0000_0258);
    wr(OFS_CTRL, 32'h1);
    repeat (60) @(posedge clk);
    apb(1'b0, OFS_INTEG, 32'h0, rd_a);
    repeat (36) @(posedge clk);
    apb(1'b0, OFS_INTEG, 32'h0, rd_b);
    check(rd_b - rd_a, 32'h0000_000A);
    wr(OFS_IGAIN, 32'h0000_7530);
    wr(OFS_HILIM, 32'h0000_012C);
    repeat (100) @(posedge clk);
    rchk(OFS_INTEG, 32'h0000_012C);
    rchk(OFS_OUTPUT, 32'h0000_0321);
    wr(OFS_LOLIM, 32'h0000_00C8);
    wr(OFS_MEAS, 32'h0000_07D0);
    repeat (120) @(posedge clk);
    rchk(OFS_INTEG, 32'hFFFF_FF38);
    rchk(OFS_OUTPUT, 32'h0000_012B);
    wr(OFS_IGAIN, 32'h0);
    wr(OFS_MEAS, 32'h0);
    repeat (120) @(posedge clk);
    rchk(OFS_INTEG, 32'hFFFF_FF38);
    $display("test integral done");
  endtask

  task automatic t_freq();
    wr(OFS_CTRL, 32'h0);
    wr(OFS_PGAIN, 32'h0);
    wr(OFS_OFFSET, 32'h0000_03E8);
    wr(OFS_ONTIME, 32'h0000_0003);
    wr(OFS_CTRL, 32'h3);
    flush(30);
    wait_rises();
    check({16'h0, on_clks}, 32'h0000_000C);
    check({16'h0, per_clks}, 32'h0000_0018);
    wr(OFS_ONTIME, 32'h0);
    flush(60);
    repeat (80) @(posedge clk);
    check({24'h0, rises}, 32'h0);
    check({31'h0, relay_out}, 32'h0);
    rchk(OFS_STATUS, 32'h0000_0000);
    $display("test frequency done");
  endtask

  // Reset in mid-run must restore settings and drop the relay
  task automatic t_rerst();
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    check({31'h0, relay_out}, 32'h0);
    rchk(OFS_CTRL, 32'h0000_0000);
    rchk(OFS_LOLIM, 32'h0000_03E8);
    rchk(OFS_TARGET, 32'h0000_03E8);
    rchk(OFS_PGAIN, 32'h0000_000A);
    rchk(OFS_INTEG, 32'h0000_0000);
    $display("test mid-run reset done");
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    srst = 1'b1;
    clr = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    error_cnt = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    clr <= 1'b0;
    t_reset();
    t_pwm();
    t_prop();
    t_integ();
    t_freq();
    t_rerst();
    tally_and_finish();
  end
endmodule

// >>> test/relpi_relay_load.sv
// Relay load model: measures pulse width, period and edge counts.
// Assumes relay_out is a registered level sampled on clk.
`timescale 1ns/1ps
module relpi_relay_load (
  // Clock and clear
  input  wire logic        clk,
  input  wire logic        clr,
  // Relay drive from the core
  input  wire logic        relay_out,
  // Measurements in clk cycles and edge counts
  output logic      [15:0] on_clks,
  output logic      [15:0] per_clks,
  output logic      [7:0]  rises,
  output logic      [7:0]  falls
);
  logic        last;
  logic [15:0] hi_cnt;
  logic [15:0] since;

  // Clear seeds last from the line so no false edge is counted
  always_ff @(posedge clk) begin
    last <= relay_out;
    if (clr) begin
      rises    <= 8'h00;
      falls    <= 8'h00;
      since    <= 16'h0000;
      hi_cnt   <= 16'h0000;
      on_clks  <= 16'h0000;
      per_clks <= 16'h0000;
    end else begin
      since  <= (relay_out && !last) ? 16'h0001 : since + 16'h0001;
      hi_cnt <= relay_out ? hi_cnt + 16'h0001 : 16'h0000;
      if (relay_out && !last) begin
        rises    <= rises + 8'h01;
        per_clks <= since;
      end
      if (!relay_out && last) begin
        falls   <= falls + 8'h01;
        on_clks <= hi_cnt;
      end
    end
  end
endmodule
